// ### hdl/bmfs_defs.svh
// constants for the boost mode and fault sequencer
// Behaviour
// RL1: on power-up start automatically with pre-charge limited to 500 mA
// RL2: after 750 us of pre-charge without reaching input, raise limit to 2000 mA
// RL3: after 1.5 ms of pre-charge without target, declare a fault
// RL4: on fault stop regulating, disconnect load, wait 1 ms, restart
// RL5: auto mode boost start-up uses 1.25 A limit, normal selectable on programmable variant
// RL6: pre-charge current reduced at 110 C, restored 10 C below
// RL7: enable and bypass_force_n high select auto boost/pass-through operation
// RL8: enable low, bypass_force_n high: shutdown with clamp, 10 mA sink, reverse block
// RL9: both low: low-quiescent pass-through shutdown limited to 250 mA
// RL10: enable high, bypass_force_n low: forced pass-through with 7300 mA limit
// RL11: host reaches low-quiescent shutdown from auto via skew-free pins or forced first
// RL12: falling output_restart_n discharges output to 600 mV then restarts fully
// RL13: pass-through switch current above 7.5 A declares fault and restarts
// RL14: boost valley current over limit extends off-time until it decays
// RL15: programmable variant takes threshold from register, others use fixed value
// RL16: input below 2 V disables serial port and output; resume above 2.1 V
// RL17: junction above 160 C turns off all switches until below hysteresis
// RL18: start-up failure, pre-charge regulation loss or thermal shutdown enter fault
// RL19: programmable variant signals fault by briefly pulling fault_pulse_n low
// RL20: supply_good high after successful start-up, low on any fault
// RL21: supply_good low at 10 percent undervoltage or 115 C, back below 100 C
// RL22: supply_good held high in forced pass-through and shutdown
// RL23: thresholds arrive as synchronised comparator flags, timeouts count the clock
`ifndef BMFS_DEFS_SVH
`define BMFS_DEFS_SVH

// ==========================================================
// timing
`define BMFS_CLK_MHZ 10
`define BMFS_PRECHG_STEP_US 750
`define BMFS_PRECHG_TOUT_US 1500
`define BMFS_FAULT_WAIT_US 1000
`define BMFS_FAULT_PULSE_NS 1000
`define BMFS_CNT_W 16
`define BMFS_PULSE_W 4

// ==========================================================
// comparator and pin flag positions
`define BMFS_NFLAGS 17
`define BMFS_F_EN 0
`define BMFS_F_BYPN 1
`define BMFS_F_RSTN 2
`define BMFS_F_NEAR_VIN 3
`define BMFS_F_REG_LOST 4
`define BMFS_F_BELOW_PRESET 5
`define BMFS_F_LOW_10PCT 6
`define BMFS_F_DISCHARGED 7
`define BMFS_F_BYP_OVERCUR 8
`define BMFS_F_VALLEY_OVER 9
`define BMFS_F_DIE_110 10
`define BMFS_F_DIE_BELOW_100 11
`define BMFS_F_DIE_115 12
`define BMFS_F_TJ_160 13
`define BMFS_F_TJ_RELEASE 14
`define BMFS_F_VIN_LOW 15
`define BMFS_F_VIN_OK 16

// ==========================================================
// fixed boost threshold and threshold width
`define BMFS_ILIM_FIXED 8'h80
`define BMFS_THR_W 8
`endif

// ### hdl/bmfs_pkg.sv
// types for the boost mode and fault sequencer
package bmfs_pkg;
   typedef enum logic [3:0] {
      BMFS_ST_LOCKOUT = 4'h0,
      BMFS_ST_PRECHG = 4'h1,
      BMFS_ST_BOOST_START = 4'h3,
      BMFS_ST_RUN = 4'h2,
      BMFS_ST_FORCED = 4'h4,
      BMFS_ST_DISCHARGE = 4'h5,
      BMFS_ST_FAULT_WAIT = 4'h6,
      BMFS_ST_TSD = 4'h7,
      BMFS_ST_SHDN = 4'hC,
      BMFS_ST_LOWQ = 4'hD
   } bmfs_state_t;

   typedef enum logic [1:0] {
      BMFS_MODE_LOWQ = 2'h0,
      BMFS_MODE_SHDN = 2'h1,
      BMFS_MODE_FORCED = 2'h2,
      BMFS_MODE_AUTO = 2'h3
   } bmfs_mode_t;

   typedef enum logic [2:0] {
      BMFS_ILIM_OFF = 3'h0,
      BMFS_ILIM_500MA = 3'h1,
      BMFS_ILIM_2000MA = 3'h2,
      BMFS_ILIM_1250MA = 3'h3,
      BMFS_ILIM_NORMAL = 3'h4,
      BMFS_ILIM_7300MA = 3'h5,
      BMFS_ILIM_250MA = 3'h6
   } bmfs_ilim_t;
endpackage

// ### hdl/bmfs_flag_if.sv
// carrier of raw and synchronised comparator and pin flags
`timescale 1ns/1ps
interface bmfs_flag_if #(parameter int W = 17);
   logic [W-1:0] raw;
   logic [W-1:0] synced;
   modport sync_side (input raw, output synced);
   modport seq_side (output raw, input synced);
endinterface

// ### hdl/bmfs_sync.sv
// two-stage synchroniser for asynchronous flags
`timescale 1ns/1ps
module bmfs_sync #(
   parameter int W = 17
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // flags
   bmfs_flag_if.sync_side flags
);
   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } bmfs_sync_regs_t;

   bmfs_sync_regs_t sync_reg;
   bmfs_sync_regs_t sync_next;

   always_comb begin
      sync_next.stage1 = flags.raw;
      sync_next.stage2 = sync_reg.stage1;
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         sync_reg <= '0;
      end else begin
         sync_reg <= sync_next;
      end
   end

   assign flags.synced = sync_reg.stage2;
endmodule

// ### hdl/bmfs_seq.sv
// start-up, mode and fault sequencer of the boost front end
`timescale 1ns/1ps
`include "bmfs_defs.svh"
module bmfs_seq #(
   parameter int PRECHG_STEP_CYC = `BMFS_PRECHG_STEP_US * `BMFS_CLK_MHZ,
   parameter int PRECHG_TOUT_CYC = `BMFS_PRECHG_TOUT_US * `BMFS_CLK_MHZ,
   parameter int FAULT_WAIT_CYC = `BMFS_FAULT_WAIT_US * `BMFS_CLK_MHZ,
   parameter logic [`BMFS_THR_W-1:0] ILIM_FIXED = `BMFS_ILIM_FIXED
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // host pins
   input wire logic enable,
   input wire logic bypass_force_n,
   input wire logic output_restart_n,
   // comparator flags
   input wire logic vout_near_vin,
   input wire logic prechg_reg_lost,
   input wire logic vout_below_preset,
   input wire logic vout_low_10pct,
   input wire logic vout_discharged,
   input wire logic bypass_overcurrent,
   input wire logic valley_over_limit,
   input wire logic die_above_110,
   input wire logic die_below_100,
   input wire logic die_above_115,
   input wire logic tj_above_160,
   input wire logic tj_below_release,
   input wire logic vin_below_lockout,
   input wire logic vin_above_release,
   // configuration
   input wire logic variant_programmable,
   input wire logic fault_signal_en,
   input wire logic boost_ilim_normal,
   input wire logic [`BMFS_THR_W-1:0] ilim_code,
   // power stage controls
   output logic precharge_en,
   output logic charge_reduce,
   output bmfs_pkg::bmfs_ilim_t ilim_sel,
   output logic [`BMFS_THR_W-1:0] ilim_threshold,
   output logic switches_en,
   output logic load_connect,
   output logic bypass_en,
   output logic clamp_en,
   output logic discharge_en,
   output logic offtime_extend,
   output logic serial_if_en,
   // status
   output bmfs_pkg::bmfs_state_t seq_state,
   output logic fault_pulse_n_out,
   output logic fault_pulse_n_oe,
   output logic supply_good
);
   import bmfs_pkg::*;

   localparam int PULSE_CYC = (`BMFS_FAULT_PULSE_NS * `BMFS_CLK_MHZ) / 1000;
   localparam logic [`BMFS_CNT_W-1:0] STEP_LAST = `BMFS_CNT_W'(PRECHG_STEP_CYC - 1);
   localparam logic [`BMFS_CNT_W-1:0] TOUT_LAST = `BMFS_CNT_W'(PRECHG_TOUT_CYC - 1);
   localparam logic [`BMFS_CNT_W-1:0] WAIT_LAST = `BMFS_CNT_W'(FAULT_WAIT_CYC - 1);
   localparam logic [`BMFS_PULSE_W-1:0] PULSE_LOAD = `BMFS_PULSE_W'(PULSE_CYC);

   typedef struct packed {
      bmfs_state_t state;
      logic [`BMFS_CNT_W-1:0] cnt;
      logic uvlo_lock;
      logic tsd_lock;
      logic therm_reduce;
      logic pg_hot;
      logic restart_prev;
      logic [`BMFS_PULSE_W-1:0] pulse_cnt;
      bmfs_ilim_t ilim;
      logic [`BMFS_THR_W-1:0] thr;
      logic precharge_en;
      logic switches_en;
      logic load_connect;
      logic bypass_en;
      logic clamp_en;
      logic discharge_en;
      logic offtime_extend;
      logic serial_if_en;
      logic charge_reduce;
      logic fault_oe;
      logic supply_good;
   } bmfs_regs_t;

   bmfs_regs_t seq_reg;
   bmfs_regs_t seq_next;

   // ==========================================================
   // synchronisers
   bmfs_flag_if #(.W(`BMFS_NFLAGS)) flags ();

   always_comb begin
      flags.raw = '0;
      flags.raw[`BMFS_F_EN] = enable;
      flags.raw[`BMFS_F_BYPN] = bypass_force_n;
      flags.raw[`BMFS_F_RSTN] = output_restart_n;
      flags.raw[`BMFS_F_NEAR_VIN] = vout_near_vin;
      flags.raw[`BMFS_F_REG_LOST] = prechg_reg_lost;
      flags.raw[`BMFS_F_BELOW_PRESET] = vout_below_preset;
      flags.raw[`BMFS_F_LOW_10PCT] = vout_low_10pct;
      flags.raw[`BMFS_F_DISCHARGED] = vout_discharged;
      flags.raw[`BMFS_F_BYP_OVERCUR] = bypass_overcurrent;
      flags.raw[`BMFS_F_VALLEY_OVER] = valley_over_limit;
      flags.raw[`BMFS_F_DIE_110] = die_above_110;
      flags.raw[`BMFS_F_DIE_BELOW_100] = die_below_100;
      flags.raw[`BMFS_F_DIE_115] = die_above_115;
      flags.raw[`BMFS_F_TJ_160] = tj_above_160;
      flags.raw[`BMFS_F_TJ_RELEASE] = tj_below_release;
      flags.raw[`BMFS_F_VIN_LOW] = vin_below_lockout;
      flags.raw[`BMFS_F_VIN_OK] = vin_above_release;
   end

   bmfs_sync #(.W(`BMFS_NFLAGS)) u_sync (
      .clock(clock),
      .resetn(resetn),
      .flags(flags)
   );

   logic [`BMFS_NFLAGS-1:0] f;
   assign f = flags.synced; // RL23

   // ==========================================================
   // mode decoding
   function automatic bmfs_mode_t bmfs_decode(input logic en, input logic byp_n);
      bmfs_mode_t m;
      m = bmfs_mode_t'({en, byp_n});
      return m;
   endfunction

   function automatic bmfs_state_t bmfs_mode_state(input bmfs_mode_t m);
      bmfs_state_t s;
      unique case (m)
         BMFS_MODE_AUTO: s = BMFS_ST_PRECHG; // RL7
         BMFS_MODE_SHDN: s = BMFS_ST_SHDN; // RL8
         BMFS_MODE_LOWQ: s = BMFS_ST_LOWQ; // RL9
         BMFS_MODE_FORCED: s = BMFS_ST_FORCED; // RL10
      endcase
      return s;
   endfunction

   // ==========================================================
   // next state
   bmfs_mode_t mode;
   logic fault;
   logic restart_edge;
   logic active;

   always_comb begin
      seq_next = seq_reg;
      mode = bmfs_decode(f[`BMFS_F_EN], f[`BMFS_F_BYPN]);
      fault = 1'b0;
      active = 1'b0;
      restart_edge = seq_reg.restart_prev & ~f[`BMFS_F_RSTN]; // RL12
      seq_next.restart_prev = f[`BMFS_F_RSTN];
      seq_next.cnt = `BMFS_CNT_W'(seq_reg.cnt + 1'b1);

      // hysteresis latches, set side wins
      if (f[`BMFS_F_VIN_LOW]) begin
         seq_next.uvlo_lock = 1'b1; // RL16
      end else if (f[`BMFS_F_VIN_OK]) begin
         seq_next.uvlo_lock = 1'b0; // RL16
      end
      if (f[`BMFS_F_TJ_160]) begin
         seq_next.tsd_lock = 1'b1; // RL17
      end else if (f[`BMFS_F_TJ_RELEASE]) begin
         seq_next.tsd_lock = 1'b0; // RL17
      end
      if (f[`BMFS_F_DIE_110]) begin
         seq_next.therm_reduce = 1'b1; // RL6
      end else if (f[`BMFS_F_DIE_BELOW_100]) begin
         seq_next.therm_reduce = 1'b0; // RL6
      end
      if (f[`BMFS_F_DIE_115]) begin
         seq_next.pg_hot = 1'b1; // RL21
      end else if (f[`BMFS_F_DIE_BELOW_100]) begin
         seq_next.pg_hot = 1'b0; // RL21
      end

      if (seq_next.uvlo_lock) begin
         seq_next.state = BMFS_ST_LOCKOUT; // RL16
         seq_next.cnt = '0;
      end else if (seq_next.tsd_lock) begin
         fault = (seq_reg.state != BMFS_ST_TSD) && (seq_reg.state != BMFS_ST_LOCKOUT); // RL18
         seq_next.state = BMFS_ST_TSD; // RL17
         seq_next.cnt = '0;
      end else begin
         unique case (seq_reg.state)
            BMFS_ST_LOCKOUT: begin
               seq_next.state = BMFS_ST_PRECHG; // RL1
               seq_next.cnt = '0;
            end
            BMFS_ST_TSD: begin
               seq_next.state = BMFS_ST_FAULT_WAIT; // RL4
               seq_next.cnt = '0;
            end
            BMFS_ST_PRECHG: begin
               if (f[`BMFS_F_REG_LOST] || seq_reg.cnt >= TOUT_LAST) begin
                  fault = 1'b1; // RL3 RL18
               end else if (f[`BMFS_F_NEAR_VIN]) begin
                  seq_next.state = (mode == BMFS_MODE_AUTO) ? BMFS_ST_BOOST_START
                                                           : bmfs_mode_state(mode); // RL5
               end
            end
            BMFS_ST_BOOST_START: begin
               if (mode != BMFS_MODE_AUTO) begin
                  seq_next.state = bmfs_mode_state(mode);
               end else if (!f[`BMFS_F_BELOW_PRESET]) begin
                  seq_next.state = BMFS_ST_RUN; // RL20
               end
            end
            BMFS_ST_RUN: begin
               // both pins follow at once only if the host keeps them skew free
               if (f[`BMFS_F_BYP_OVERCUR]) begin
                  fault = 1'b1; // RL13
               end else if (mode != BMFS_MODE_AUTO) begin
                  seq_next.state = bmfs_mode_state(mode); // RL11
               end
            end
            BMFS_ST_FORCED: begin
               if (f[`BMFS_F_BYP_OVERCUR]) begin
                  fault = 1'b1; // RL10 RL13
               end else if (bmfs_mode_state(mode) != seq_reg.state) begin
                  seq_next.state = bmfs_mode_state(mode);
                  seq_next.cnt = '0;
               end
            end
            BMFS_ST_SHDN, BMFS_ST_LOWQ: begin
               if (bmfs_mode_state(mode) != seq_reg.state) begin
                  seq_next.state = bmfs_mode_state(mode);
                  seq_next.cnt = '0;
               end
            end
            BMFS_ST_FAULT_WAIT: begin
               if (seq_reg.cnt >= WAIT_LAST) begin
                  seq_next.state = BMFS_ST_PRECHG; // RL4
                  seq_next.cnt = '0;
               end
            end
            BMFS_ST_DISCHARGE: begin
               if (f[`BMFS_F_DISCHARGED]) begin
                  seq_next.state = BMFS_ST_PRECHG; // RL12
                  seq_next.cnt = '0;
               end
            end
            default: begin
               seq_next.state = BMFS_ST_LOCKOUT;
               seq_next.cnt = '0;
            end
         endcase
         active = (seq_reg.state != BMFS_ST_FAULT_WAIT) && (seq_reg.state != BMFS_ST_TSD) &&
                  (seq_reg.state != BMFS_ST_LOCKOUT) && (seq_reg.state != BMFS_ST_DISCHARGE);
         if (fault) begin
            seq_next.state = BMFS_ST_FAULT_WAIT; // RL4
            seq_next.cnt = '0;
         end else if (restart_edge && active) begin
            seq_next.state = BMFS_ST_DISCHARGE; // RL12
            seq_next.cnt = '0;
         end
      end

      // fault pulse on the open-drain line
      if (fault && variant_programmable && fault_signal_en) begin
         seq_next.pulse_cnt = PULSE_LOAD; // RL19
      end else if (seq_reg.pulse_cnt != '0) begin
         seq_next.pulse_cnt = `BMFS_PULSE_W'(seq_reg.pulse_cnt - 1'b1);
      end
      seq_next.fault_oe = seq_next.pulse_cnt != '0; // RL19

      // power stage controls follow the next state
      seq_next.precharge_en = seq_next.state == BMFS_ST_PRECHG;
      seq_next.charge_reduce = seq_next.therm_reduce & seq_next.precharge_en; // RL6
      seq_next.switches_en = (seq_next.state == BMFS_ST_PRECHG) ||
                             (seq_next.state == BMFS_ST_BOOST_START) ||
                             (seq_next.state == BMFS_ST_RUN); // RL4 RL17
      seq_next.load_connect = seq_next.switches_en || (seq_next.state == BMFS_ST_FORCED) ||
                              (seq_next.state == BMFS_ST_LOWQ); // RL4
      seq_next.bypass_en = (seq_next.state == BMFS_ST_FORCED) ||
                           (seq_next.state == BMFS_ST_LOWQ); // RL9 RL10
      seq_next.clamp_en = seq_next.state == BMFS_ST_SHDN; // RL8
      seq_next.discharge_en = seq_next.state == BMFS_ST_DISCHARGE; // RL12
      seq_next.serial_if_en = !seq_next.uvlo_lock; // RL16
      seq_next.thr = variant_programmable ? ilim_code : ILIM_FIXED; // RL15
      seq_next.offtime_extend = ((seq_next.state == BMFS_ST_BOOST_START) ||
                                 (seq_next.state == BMFS_ST_RUN)) &&
                                f[`BMFS_F_VALLEY_OVER]; // RL14
      unique case (seq_next.state)
         BMFS_ST_PRECHG: begin
            seq_next.ilim = (seq_next.cnt > STEP_LAST) ? BMFS_ILIM_2000MA
                                                      : BMFS_ILIM_500MA; // RL1 RL2
         end
         BMFS_ST_BOOST_START: begin
            seq_next.ilim = (variant_programmable && boost_ilim_normal) ? BMFS_ILIM_NORMAL
                                                                      : BMFS_ILIM_1250MA; // RL5
         end
         BMFS_ST_RUN: seq_next.ilim = BMFS_ILIM_NORMAL;
         BMFS_ST_FORCED: seq_next.ilim = BMFS_ILIM_7300MA; // RL10
         BMFS_ST_LOWQ: seq_next.ilim = BMFS_ILIM_250MA; // RL9
         default: seq_next.ilim = BMFS_ILIM_OFF;
      endcase
      seq_next.supply_good = (seq_next.state == BMFS_ST_FORCED) ||
                             (seq_next.state == BMFS_ST_SHDN) ||
                             (seq_next.state == BMFS_ST_LOWQ) || // RL22
                             ((seq_next.state == BMFS_ST_RUN) && !f[`BMFS_F_LOW_10PCT] &&
                              !seq_next.pg_hot); // RL20 RL21
   end

   always_ff @(posedge clock) begin
      if (!resetn) begin
         seq_reg <= '0;
      end else begin
         seq_reg <= seq_next;
      end
   end

   // ==========================================================
   // outputs
   assign precharge_en = seq_reg.precharge_en;
   assign charge_reduce = seq_reg.charge_reduce; // RL6
   assign ilim_sel = seq_reg.ilim;
   assign ilim_threshold = seq_reg.thr;
   assign switches_en = seq_reg.switches_en;
   assign load_connect = seq_reg.load_connect;
   assign bypass_en = seq_reg.bypass_en;
   assign clamp_en = seq_reg.clamp_en;
   assign discharge_en = seq_reg.discharge_en;
   assign offtime_extend = seq_reg.offtime_extend;
   assign serial_if_en = seq_reg.serial_if_en;
   assign seq_state = seq_reg.state;
   assign fault_pulse_n_out = 1'b0;
   assign fault_pulse_n_oe = seq_reg.fault_oe;
   assign supply_good = seq_reg.supply_good;

   // ==========================================================
   // checks
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);

   a_prechg_low_limit: assert property ((seq_reg.state == BMFS_ST_PRECHG) && // RL1
      (seq_reg.cnt <= STEP_LAST) |-> (seq_reg.ilim == BMFS_ILIM_500MA))
      else $error("pre-charge limit not 500 mA");
   a_prechg_step_limit: assert property ((seq_reg.state == BMFS_ST_PRECHG) && // RL2
      (seq_reg.cnt > STEP_LAST) |-> (seq_reg.ilim == BMFS_ILIM_2000MA))
      else $error("pre-charge limit not raised");
   a_prechg_timeout: assert property ((seq_reg.state == BMFS_ST_PRECHG) // RL3
      |-> (seq_reg.cnt <= TOUT_LAST))
      else $error("pre-charge overran its timeout");
   a_fault_wait_off: assert property ((seq_reg.state == BMFS_ST_FAULT_WAIT) // RL4
      |-> !seq_reg.switches_en && !seq_reg.load_connect && (seq_reg.cnt <= WAIT_LAST))
      else $error("fault wait not off or overran");
   a_boost_start_lim: assert property ((seq_reg.state == BMFS_ST_BOOST_START) && // RL5
      !$past(variant_programmable) |-> (seq_reg.ilim == BMFS_ILIM_1250MA))
      else $error("boost start-up limit wrong");
   a_shdn_clamp: assert property ((seq_reg.state == BMFS_ST_SHDN) // RL8
      |-> seq_reg.clamp_en && !seq_reg.switches_en && seq_reg.supply_good)
      else $error("shutdown clamp not active");
   a_lowq_limit: assert property ((seq_reg.state == BMFS_ST_LOWQ) // RL9
      |-> (seq_reg.ilim == BMFS_ILIM_250MA) && seq_reg.bypass_en)
      else $error("low-quiescent pass-through wrong");
   a_forced_limit: assert property ((seq_reg.state == BMFS_ST_FORCED) // RL10
      |-> (seq_reg.ilim == BMFS_ILIM_7300MA) && seq_reg.supply_good)
      else $error("forced pass-through wrong");
   a_overcur_fault: assert property ((seq_reg.state == BMFS_ST_FORCED) && // RL13
      f[`BMFS_F_BYP_OVERCUR] && !seq_next.uvlo_lock && !seq_next.tsd_lock
      |=> (seq_reg.state == BMFS_ST_FAULT_WAIT))
      else $error("overcurrent did not fault");
   a_uvlo_disable: assert property (seq_reg.uvlo_lock // RL16
      |-> !seq_reg.serial_if_en && (seq_reg.state == BMFS_ST_LOCKOUT))
      else $error("lockout not disabling");
   a_tsd_off: assert property ((seq_reg.state == BMFS_ST_TSD) // RL17
      |-> !seq_reg.switches_en && !seq_reg.bypass_en)
      else $error("thermal shutdown left switches on");
   a_pulse_len: assert property ($rose(seq_reg.fault_oe) // RL19
      |-> seq_reg.fault_oe[*8])
      else $error("fault pulse too short");
   a_pg_fault: assert property ((seq_reg.state == BMFS_ST_FAULT_WAIT) // RL20
      |-> !seq_reg.supply_good)
      else $error("supply_good high in fault");
   a_valley_ext: assert property (seq_reg.offtime_extend // RL14
      |-> (seq_reg.state == BMFS_ST_RUN) || (seq_reg.state == BMFS_ST_BOOST_START))
      else $error("off-time extended outside boost");
endmodule

// ### tb/bmfs_host_model.sv
// host processor model driving the two mode pins
`timescale 1ns/1ps
module bmfs_host_model
   import bmfs_pkg::*;
(
   // clock and request
   input wire logic clock,
   input wire bmfs_mode_t mode_req,
   // mode pins
   output logic enable,
   output logic bypass_force_n
);
   initial {enable, bypass_force_n} = 2'b11;
   // both pins from one register, so no skew between them
   always @(negedge clock) begin
      {enable, bypass_force_n} <= mode_req;
   end
endmodule

// ### tb/tb_boost_mode_fault_sequencer.sv
// self-checking bench of the boost mode and fault sequencer
`timescale 1ns/1ps
module tb_boost_mode_fault_sequencer;
   import bmfs_pkg::*;
   logic clock, resetn, output_restart_n, vout_near_vin, prechg_reg_lost, vout_below_preset;
   logic vout_low_10pct, vout_discharged, bypass_overcurrent, valley_over_limit, die_above_110;
   logic die_below_100, die_above_115, tj_above_160, tj_below_release, vin_below_lockout;
   logic vin_above_release, variant_programmable, fault_signal_en, boost_ilim_normal;
   logic enable, bypass_force_n, precharge_en, charge_reduce, switches_en, load_connect;
   logic bypass_en, clamp_en, discharge_en, offtime_extend, serial_if_en, supply_good;
   logic fault_pulse_n_out, fault_pulse_n_oe;
   logic [7:0] ilim_code, ilim_threshold;
   logic [31:0] rnd;
   bmfs_ilim_t ilim_sel;
   bmfs_state_t seq_state;
   bmfs_mode_t mode_req;
   bmfs_mode_t mt [3] = '{BMFS_MODE_FORCED, BMFS_MODE_SHDN, BMFS_MODE_LOWQ};
   bmfs_state_t ms [3] = '{BMFS_ST_FORCED, BMFS_ST_SHDN, BMFS_ST_LOWQ};
   int errors, compares;
   int cyc = 0;
   int pulse = 0;
   bmfs_seq #(.PRECHG_STEP_CYC(8), .PRECHG_TOUT_CYC(16), .FAULT_WAIT_CYC(12)) uut (.*);
   bmfs_host_model host (.clock, .mode_req, .enable, .bypass_force_n);
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (fault_pulse_n_oe === 1'b1) pulse <= pulse + 1;
      if (cyc == 3000) begin
         errors++;
         complete_run();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] v);
      v ^= v << 13;
      v ^= v >> 17;
      v ^= v << 5;
      return v;
   endfunction
   function automatic logic [7:0] thr(input logic prog, input logic [7:0] code);
      return prog ? code : 8'h80;
   endfunction
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wst(input bmfs_state_t s);
      int n;
      n = 0;
      while (seq_state !== s && n < 40) begin
         @(negedge clock);
         n++;
      end
      chk(8'(seq_state), 8'(s));
   endtask
   task automatic complete_run();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      {resetn, vout_near_vin, prechg_reg_lost, vout_low_10pct, vout_discharged} = '0;
      {bypass_overcurrent, valley_over_limit, die_above_110, die_above_115} = '0;
      {tj_above_160, vin_below_lockout, boost_ilim_normal} = '0;
      {die_below_100, tj_below_release, vin_above_release, output_restart_n} = '1;
      {variant_programmable, fault_signal_en, vout_below_preset} = '1;
      ilim_code = 8'h3C;
      mode_req = BMFS_MODE_AUTO;
      rnd = 32'h0402;
      errors = 0;
      compares = 0;
      repeat (3) @(negedge clock);
      resetn = 1'b1;
      // ==========================================================
      // power-up pre-charge steps and timeout fault
      wst(BMFS_ST_PRECHG);
      chk(8'(precharge_en), 8'h01);
      chk(8'(fault_pulse_n_out), 8'h00);
      repeat (4) @(negedge clock);
      chk(8'(ilim_sel), 8'(BMFS_ILIM_500MA));
      {die_above_110, die_below_100} = 2'b10;
      repeat (8) @(negedge clock);
      chk(8'(ilim_sel), 8'(BMFS_ILIM_2000MA));
      chk(8'(charge_reduce), 8'h01);
      {die_above_110, die_below_100} = 2'b01;
      wst(BMFS_ST_FAULT_WAIT);
      chk(8'(load_connect), 8'h00);
      chk(8'(supply_good), 8'h00);
      repeat (11) @(negedge clock);
      chk(pulse[7:0], 8'h0A);
      wst(BMFS_ST_PRECHG);
      chk(8'(charge_reduce), 8'h00);
      $display("test power-up done");
      // ==========================================================
      // boost start-up, run, valley and undervoltage flag
      vout_near_vin = 1'b1;
      wst(BMFS_ST_BOOST_START);
      chk(8'(ilim_sel), 8'(BMFS_ILIM_1250MA));
      boost_ilim_normal = 1'b1;
      @(negedge clock);
      chk(8'(ilim_sel), 8'(BMFS_ILIM_NORMAL));
      {boost_ilim_normal, vout_below_preset} = 2'b00;
      wst(BMFS_ST_RUN);
      chk(8'(supply_good), 8'h01);
      valley_over_limit = 1'b1;
      vout_low_10pct = 1'b1;
      repeat (4) @(negedge clock);
      chk(8'(offtime_extend), 8'h01);
      chk(8'(supply_good), 8'h00);
      {valley_over_limit, vout_low_10pct, die_above_115, die_below_100} = 4'b0010;
      repeat (4) @(negedge clock);
      chk(8'(offtime_extend), 8'h00);
      chk(8'(supply_good), 8'h00);
      {die_above_115, die_below_100} = 2'b01;
      repeat (4) @(negedge clock);
      chk(8'(supply_good), 8'h01);
      $display("test run done");
      // ==========================================================
      // mode pins, then back to auto through pre-charge
      for (int i = 0; i < 3; i++) begin
         mode_req = mt[i];
         wst(ms[i]);
         chk(8'(supply_good), 8'h01);
         chk(8'(bypass_en), 8'(i != 1));
         chk(8'(clamp_en), 8'(i == 1));
         mode_req = BMFS_MODE_AUTO;
         wst(BMFS_ST_PRECHG);
         wst(BMFS_ST_RUN);
      end
      $display("test modes done");
      // ==========================================================
      // pass-through overcurrent, restart, thermal and lockout
      mode_req = BMFS_MODE_FORCED;
      wst(BMFS_ST_FORCED);
      bypass_overcurrent = 1'b1;
      wst(BMFS_ST_FAULT_WAIT);
      bypass_overcurrent = 1'b0;
      mode_req = BMFS_MODE_AUTO;
      wst(BMFS_ST_RUN);
      output_restart_n = 1'b0;
      wst(BMFS_ST_DISCHARGE);
      chk(8'(discharge_en), 8'h01);
      {output_restart_n, vout_discharged} = 2'b11;
      wst(BMFS_ST_PRECHG);
      vout_discharged = 1'b0;
      wst(BMFS_ST_RUN);
      {tj_above_160, tj_below_release} = 2'b10;
      wst(BMFS_ST_TSD);
      chk(8'(switches_en), 8'h00);
      {tj_above_160, tj_below_release} = 2'b01;
      wst(BMFS_ST_FAULT_WAIT);
      {vin_below_lockout, vin_above_release} = 2'b10;
      wst(BMFS_ST_LOCKOUT);
      chk(8'(serial_if_en), 8'h00);
      {vin_below_lockout, vin_above_release} = 2'b01;
      wst(BMFS_ST_PRECHG);
      $display("test protection done");
      // ==========================================================
      // random threshold codes on both variants
      for (int i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         ilim_code = rnd[7:0];
         variant_programmable = rnd[8];
         repeat (4) @(negedge clock);
         chk(ilim_threshold, thr(rnd[8], rnd[7:0]));
      end
      $display("test threshold done");
      complete_run();
   end
endmodule
